// ==== hw/eitc_trigger_config.sv ====
// Purpose: trigger type selection and detection for 24 external lines, APB slave
// Assumes: APB master as usual; one wait state on every access
// Notes: sticky status per line, enable mask, one level interrupt output
`timescale 1ns/1ps

// What this block does
// RQ1 - twenty-four external lines, each with its own trigger method
// RQ2 - code 000 requests while line low, 001 while line high
// RQ3 - codes 01x falling, 10x rising, 11x both edges; low bit ignored
// RQ4 - sources hold a level at least 40 ns on lines 0 to 15
// RQ5 - first register: lines 0 to 7, four-bit stride, bits 2:0 to 30:28
// RQ6 - second register: lines 8 to 15, nibble top bits reserved
// RQ7 - third register: lines 16 to 23 on the same stride
// RQ8 - third register nibble top bit enables that line's noise filter
// RQ9 - all three registers read and write, reset to zero
// RQ10 - inputs synchronised; edges by comparing current and previous sample
// RQ11 - filter disabled means synchronised input feeds detector directly
module eitc_trigger_config
    import eitc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_LINES-1:0] external_request_line,
    output logic [NUM_LINES-1:0] trigger_request,
    output logic irq
);

    function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] off);
        return a == off;
    endfunction

    logic [31:0] cfg_r [NUM_CFG];
    logic [23:0] status_r, enable_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;

    logic [NUM_CFG-1:0] cfg_hit;
    logic stat_hit, en_hit, mapped, access, done, wr, rd_first;
    logic [31:0] rd_val;
    logic [23:0] line_req, clr_bits, status_nxt, enable_nxt;
    eitc_line_cfg_t line_cfg [NUM_LINES];

    // bus decode
    assign access = psel & penable;
    assign done = access & pready_r;
    assign wr = done & pwrite;
    assign rd_first = access & ~pready_r;
    assign stat_hit = addr_hit(paddr, STATUS_ADDR);
    assign en_hit = addr_hit(paddr, ENABLE_ADDR);
    assign mapped = (|cfg_hit) | stat_hit | en_hit;

    genvar j, i;
    generate
        for (j = 0; j < NUM_CFG; j++) begin : g_cfg
            assign cfg_hit[j] = addr_hit(paddr, CFG_ADDR[j]);
            // reserved bits never stored, so they read back as zero
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_r[j] <= CFG_RESET; // RQ9
                end else if (wr && cfg_hit[j]) begin
                    cfg_r[j] <= pwdata & CFG_MASK[j]; // RQ5 RQ6 RQ7
                end
            end
        end

        for (i = 0; i < NUM_LINES; i++) begin : g_line
            localparam int unsigned R = i / LINES_PER_REG;
            localparam int unsigned B = (i % LINES_PER_REG) * FIELD_STRIDE;
            assign line_cfg[i].mode = cfg_r[R][B + MODE_LSB +: 3]; // RQ1
            // lines below 16 always run through the filter
            assign line_cfg[i].filt_on = (i >= FILT_FIRST_LINE) ? cfg_r[R][B + FILT_BIT] : 1'b1; // RQ8
            eitc_line_detect #(
                .FILT_CYCLES(FILT_CYC)
            ) u_det (
                .pclk(pclk),
                .presetn(presetn),
                .line_in(external_request_line[i]),
                .cfg(line_cfg[i]),
                .req_o(line_req[i])
            );
        end
    endgenerate

    always_comb begin
        rd_val = 32'h0000_0000;
        for (int k = 0; k < NUM_CFG; k++) begin
            if (cfg_hit[k]) begin
                rd_val = cfg_r[k]; // RQ9
            end
        end
        if (stat_hit) begin
            rd_val = {8'h00, status_r};
        end
        if (en_hit) begin
            rd_val = {8'h00, enable_r};
        end
    end

    // a request in the same cycle as its write-one-to-clear keeps the bit set
    assign clr_bits = (wr && stat_hit) ? pwdata[23:0] : 24'h00_0000;
    assign status_nxt = (status_r & ~clr_bits) | line_req; // RQ1
    assign enable_nxt = (wr && en_hit) ? pwdata[23:0] : enable_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= STATUS_RESET;
            enable_r <= ENABLE_RESET;
        end else begin
            status_r <= status_nxt;
            enable_r <= enable_nxt;
        end
    end

    // one wait state so read data comes straight from a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= rd_first;
            pslverr_r <= rd_first & ~mapped;
            prdata_r <= (rd_first && !pwrite) ? rd_val : prdata_r;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign trigger_request = line_req;
    assign irq = |(status_r & enable_r);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cfg_reset_zero: assert property ($rose(presetn) |-> // RQ9
        (cfg_r[0] == 32'h0000_0000 && cfg_r[1] == 32'h0000_0000 && cfg_r[2] == 32'h0000_0000))
        else $error("configuration not zero after reset");
    a_lo_field_map: assert property ((wr && cfg_hit[0]) |=> // RQ5
        (line_cfg[0].mode == $past(pwdata[2:0]) && line_cfg[7].mode == $past(pwdata[30:28])))
        else $error("first register fields misplaced");
    a_mid_reserved_zero: assert property ((wr && cfg_hit[1]) |=> // RQ6
        (!cfg_r[1][31] && !cfg_r[1][3] && line_cfg[15].mode == $past(pwdata[30:28])))
        else $error("second register reserved bit stored");
    a_hi_field_map: assert property ((wr && cfg_hit[2]) |=> // RQ7
        (line_cfg[16].mode == $past(pwdata[2:0]) && line_cfg[23].mode == $past(pwdata[30:28])))
        else $error("third register fields misplaced");
    a_hi_filter_bits: assert property ((wr && cfg_hit[2]) |=> // RQ8
        (line_cfg[23].filt_on == $past(pwdata[31]) && line_cfg[16].filt_on == $past(pwdata[3])))
        else $error("filter enable bits misplaced");
    a_req_sets_status: assert property ((line_req != 24'h00_0000) |=> // RQ1
        ((status_r & $past(line_req)) == $past(line_req)))
        else $error("request did not set its status bit");
    a_cfg_read_back: assert property ((rd_first && !pwrite && cfg_hit[2]) |=> // RQ9
        (pready && prdata == $past(cfg_r[2])))
        else $error("configuration read back mismatch");
    a_one_wait_state: assert property (rd_first |=> pready) // RQ9
        else $error("access not answered after one wait state");
    a_ready_one_cycle: assert property (pready |=> !pready) // RQ9
        else $error("ready held longer than one cycle");
    a_unmapped_error: assert property ((rd_first && !mapped) |=> pslverr) // RQ9
        else $error("unmapped address without error response");
    a_mapped_no_error: assert property ((rd_first && mapped) |=> !pslverr) // RQ9
        else $error("error response on a mapped address");
    a_unmapped_read_zero: assert property ((rd_first && !pwrite && !mapped) |=> // RQ9
        (prdata == 32'h0000_0000))
        else $error("unmapped read returned data");
    a_cfg_only_on_write: assert property (!(wr && (|cfg_hit)) |=> // RQ9
        ($stable(cfg_r[0]) && $stable(cfg_r[1]) && $stable(cfg_r[2])))
        else $error("configuration changed without a write");
    a_lo_reserved_zero: assert property ((wr && cfg_hit[0]) |=> // RQ5
        (!cfg_r[0][31] && !cfg_r[0][3] && line_cfg[0].filt_on))
        else $error("first register reserved bit stored");
    a_mid_field_map: assert property ((wr && cfg_hit[1]) |=> // RQ6
        (line_cfg[8].mode == $past(pwdata[2:0])))
        else $error("second register fields misplaced");
    a_status_w1c: assert property ((wr && stat_hit && line_req == 24'h00_0000) |=> // RQ1
        ((status_r & $past(pwdata[23:0])) == 24'h00_0000))
        else $error("status bit not cleared by writing one");
    a_status_sticky: assert property (!(wr && stat_hit) |=> // RQ1
        ((status_r & $past(status_r)) == $past(status_r)))
        else $error("status bit dropped without a clear");
    a_enable_write: assert property ((wr && en_hit) |=> // RQ1
        (enable_r == $past(pwdata[23:0])))
        else $error("enable register write lost");

endmodule // eitc_trigger_config

// ==== hw/eitc_pkg.sv ====
// Purpose: shared constants and types for the external line trigger block
// Assumes: 32-bit APB, one aligned word per register, 40 MHz pclk
// Notes: line fields sit on a four-bit stride, eight lines per register
package eitc_pkg;

    localparam int unsigned NUM_LINES = 24;
    localparam int unsigned NUM_CFG = 3;
    localparam int unsigned LINES_PER_REG = 8;
    localparam int unsigned FIELD_STRIDE = 4;
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned FILT_BIT = 3;
    localparam int unsigned FILT_FIRST_LINE = 16;

    // register byte addresses
    localparam logic [31:0] CFG_ADDR [NUM_CFG] = '{32'h5600_0088, 32'h5600_008C, 32'h5600_0090};
    localparam logic [31:0] STATUS_ADDR = 32'h5600_00C0;
    localparam logic [31:0] ENABLE_ADDR = 32'h5600_00C4;

    // writable bits; the top bit of each nibble is a filter enable only in the last register
    localparam logic [31:0] CFG_MASK [NUM_CFG] = '{32'h7777_7777, 32'h7777_7777, 32'hFFFF_FFFF};
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [23:0] STATUS_RESET = 24'h00_0000;
    localparam logic [23:0] ENABLE_RESET = 24'h00_0000;

    // noise filter: least hold time, rounded up to whole pclk cycles
    localparam int unsigned CLK_PERIOD_PS = 25000;
    localparam int unsigned FILT_MIN_NS = 40;
    localparam int unsigned FILT_CYC_RAW = (FILT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned FILT_CYC = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
    // two sync stages plus the previous sample, all to fill after reset
    localparam int unsigned WARM_EXTRA = 3;

    localparam logic [2:0] MODE_LOW = 3'h0;
    localparam logic [2:0] MODE_HIGH = 3'h1;

    typedef enum logic [1:0] {
        TRIG_LEVEL = 2'h0,
        TRIG_FALL = 2'h1,
        TRIG_RISE = 2'h2,
        TRIG_BOTH = 2'h3
    } eitc_trig_t;

    typedef struct packed {
        logic filt_on;
        logic [2:0] mode;
    } eitc_line_cfg_t;

endpackage

// ==== hw/eitc_line_detect.sv ====
// Purpose: one line: synchroniser, noise filter, trigger detector
// Assumes: line_in is asynchronous to pclk
// Notes: req_o is registered; level modes hold it, edge modes pulse it; quiet just after reset
`timescale 1ns/1ps
module eitc_line_detect
    import eitc_pkg::*;
#(
    parameter int unsigned FILT_CYCLES = FILT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic line_in,
    input wire eitc_line_cfg_t cfg,
    output logic req_o
);
    localparam int unsigned CW = $clog2(FILT_CYCLES + 1);
    localparam int unsigned WARM = FILT_CYCLES + WARM_EXTRA;
    localparam int unsigned WW = $clog2(WARM + 1);

    logic sync1_r, sync2_r, filt_r, prev_r, req_r;
    logic [CW-1:0] cnt_r;
    logic differs, settled, cond, fall, rise, req_nxt;
    logic warm_done;
    logic [WW-1:0] warm_r;
    eitc_trig_t trig;

    // the filter output only moves once the new level has held FILT_CYCLES cycles
    assign differs = sync2_r != filt_r;
    assign settled = differs && (cnt_r == CW'(FILT_CYCLES - 1));
    assign cond = cfg.filt_on ? filt_r : sync2_r; // RQ11
    assign trig = eitc_trig_t'(cfg.mode[2:1]);
    assign fall = prev_r & ~cond; // RQ10
    assign rise = ~prev_r & cond; // RQ10
    assign req_o = req_r;
    // reset zeros in the pipeline would pose as a low level or an edge,
    // so requests wait until sync, filter and previous sample hold real values
    assign warm_done = warm_r == WW'(WARM);

    always_comb begin
        case (trig)
            TRIG_LEVEL: req_nxt = cfg.mode[0] ? cond : ~cond; // RQ2
            TRIG_FALL: req_nxt = fall; // RQ3
            TRIG_RISE: req_nxt = rise; // RQ3
            TRIG_BOTH: req_nxt = fall | rise; // RQ3
            default: req_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= line_in; // RQ10
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            filt_r <= 1'b0;
        end else begin
            cnt_r <= (!differs || settled) ? '0 : cnt_r + CW'(1);
            filt_r <= settled ? sync2_r : filt_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 1'b0;
            req_r <= 1'b0;
            warm_r <= '0;
        end else begin
            prev_r <= cond;
            req_r <= warm_done ? req_nxt : 1'b0; // RQ10
            warm_r <= warm_done ? warm_r : warm_r + WW'(1);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_warm_quiet: assert property (!warm_done |=> !req_o) // RQ10
        else $error("request raised before the line pipeline filled");
    a_low_level_req: assert property ((warm_done && cfg.mode == MODE_LOW && !cond) |=> // RQ2
        req_o)
        else $error("low level did not raise request");
    a_high_level_req: assert property ((warm_done && cfg.mode == MODE_HIGH) |=> // RQ2
        (req_o == $past(cond)))
        else $error("high level request does not follow line");
    a_fall_edge_only: assert property ((warm_done && cfg.mode[2:1] == 2'h1) |=> // RQ3
        (req_o == $past(fall)))
        else $error("falling edge mode mismatch");
    a_rise_edge_only: assert property ((warm_done && cfg.mode[2:1] == 2'h2) |=> // RQ3
        (req_o == $past(rise)))
        else $error("rising edge mode mismatch");
    a_both_edges_seen: assert property ((warm_done && prev_r != cond // RQ3
        && cfg.mode[2:1] == 2'h3) |=> req_o)
        else $error("edge missed in both edge mode");
    a_filter_settle: assert property ($rose(filt_r) |-> $past(sync2_r, 1) && $past(sync2_r, 2)) // RQ10
        else $error("filter passed a short pulse");
    a_bypass_direct: assert property ((warm_done && !cfg.filt_on // RQ11
        && cfg.mode == MODE_HIGH && sync2_r) |=> req_o)
        else $error("bypassed line did not reach detector");

endmodule // eitc_line_detect

// ==== verif/eitc_src_model.sv ====
// Purpose: stand-in for the external sources on the request lines
// Assumes: the bench holds each level it asks for at least two pclk cycles
// Notes: flip inverts a line for one cycle, a glitch that is short on purpose
`timescale 1ns/1ps
module eitc_src_model (
    input wire logic pclk,
    input wire logic [23:0] lvl,
    input wire logic [23:0] flip,
    output logic [23:0] line_out
);
    // sources switch just after the edge, never mid-cycle
    always_ff @(posedge pclk) begin
        line_out <= lvl ^ flip;
    end
endmodule // eitc_src_model

// ==== verif/testbench.sv ====
// Purpose: self-checking bench for the external line trigger block
// Assumes: two-cycle filter span; APB waits end only on pready or the timeout
// Notes: lines idle high so the default low-level mode stays quiet
`timescale 1ns/1ps
module testbench import eitc_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, er;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic [23:0] lvl = 24'hFF_FFFF, flip = '0, seen = '0, line_w, trigger_request;
    int mismatches = 0, n_checks = 0, cyc = 0, cnt = 0;
    always #12.5 pclk = ~pclk;
    eitc_src_model src (.pclk(pclk), .lvl(lvl), .flip(flip), .line_out(line_w));
    eitc_trigger_config uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_request_line(line_w), .trigger_request(trigger_request), .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // waits whole cycles, gathering requests and the high time of request 16
    task automatic wt(input int n);
        repeat (n) begin
            @(posedge pclk);
            seen = seen | trigger_request;
            if (trigger_request[16] === 1'b1) cnt++;
        end
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic t_reset();
        for (int r = 0; r < 3; r++) begin
            apb(1'b0, CFG_ADDR[r], '0);
            chk(rd, CFG_RESET);
        end
        apb(1'b1, 32'h5600_0094, 32'hFFFF_FFFF);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 32'h5600_0094, '0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk({8'h00, trigger_request}, 32'h0);
        // lines idle high: reset zeros in the pipeline must leave no request behind
        apb(1'b0, STATUS_ADDR, '0);
        chk(rd, 32'h0);
        apb(1'b0, CFG_ADDR[0], '0);
        chk({31'h0, er}, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_regs();
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, CFG_ADDR[r], 32'hFFFF_FFFF);
            apb(1'b0, CFG_ADDR[r], '0);
            chk(rd, CFG_MASK[r]);
            for (int k = 0; k < 32; k += 28) begin
                apb(1'b1, CFG_ADDR[r], 32'h1 << k);
                wt(8);
                chk({8'h00, trigger_request}, 32'h1 << (8 * r + k / 4));
            end
            apb(1'b1, CFG_ADDR[r], '0);
        end
        $display("register test done");
    endtask
    task automatic t_modes();
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, CFG_ADDR[2], 32'(c));
            wt(6);
            cnt = 0;
            lvl[16] <= 1'b0;
            wt(8);
            if (c < 2) chk({31'h0, trigger_request[16]}, 32'(c == 0));
            lvl[16] <= 1'b1;
            wt(8);
            if (c < 2) chk({31'h0, trigger_request[16]}, 32'(c == 1));
            else chk(32'(cnt), (c > 5) ? 32'h2 : 32'h1);
        end
        $display("mode test done");
    endtask
    task automatic t_filter_irq();
        lvl <= 24'hFC_FFFE;
        apb(1'b1, CFG_ADDR[0], 32'h1);
        apb(1'b1, CFG_ADDR[2], 32'h91);
        apb(1'b1, ENABLE_ADDR, 32'h1_0000);
        wt(8);
        apb(1'b1, STATUS_ADDR, 32'hFFFF_FFFF);
        wt(2);
        chk({31'h0, irq}, 32'h0);
        seen = '0;
        flip <= 24'h03_0001;
        @(posedge pclk);
        flip <= '0;
        wt(10);
        chk({8'h00, seen}, 32'h1_0000);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, STATUS_ADDR, '0);
        chk(rd, 32'h1_0000);
        apb(1'b1, ENABLE_ADDR, '0);
        wt(2);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, STATUS_ADDR, 32'h1_0000);
        apb(1'b0, STATUS_ADDR, '0);
        chk(rd, 32'h0);
        // a level held long enough passes the enabled filter
        lvl[17] <= 1'b1;
        wt(10);
        chk({8'h00, seen}, 32'h3_0000);
        $display("filter and interrupt test done");
    endtask
    // reset in mid-run; lines 0 and 16 are still low from the filter test
    task automatic t_mid_reset();
        apb(1'b1, CFG_ADDR[1], 32'h1111_1111);
        apb(1'b1, ENABLE_ADDR, 32'hFF_FFFF);
        wt(8);
        chk({31'h0, irq}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk({31'h0, irq}, 32'h0);
        for (int r = 0; r < 3; r++) begin
            apb(1'b0, CFG_ADDR[r], '0);
            chk(rd, CFG_RESET);
        end
        chk({8'h00, trigger_request}, 32'h0001_0001);
        apb(1'b0, STATUS_ADDR, '0);
        chk(rd, 32'h0001_0001);
        $display("mid-run reset test done");
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_modes();
        t_filter_irq();
        t_mid_reset();
        wrap_up();
    end
endmodule // testbench
